// ===== design/wdt_pkg.sv
// Shared constants and types for the watchdog and fetch-trap block
package wdt_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] WDT_CONFIG_OFS = 12'h034;
	localparam logic [11:0] WDT_CODE_OFS   = 12'h038;
	localparam logic [11:0] WDT_STATUS_OFS = 12'h03c;

	// ------------------------------------------------------------
	// Config register fields
	// ------------------------------------------------------------
	localparam int WDT_OUTSEL_BIT   = 0;
	localparam int WDT_TIME_LSB     = 1;
	localparam int WDT_ENABLE_BIT   = 3;
	localparam int WDT_TRAPSEL_BIT  = 4;
	localparam int WDT_RAMTRAP_BIT  = 5;
	localparam logic [5:0] WDT_CONFIG_RST = 6'h39;

	// ------------------------------------------------------------
	// Control codes
	// ------------------------------------------------------------
	localparam logic [7:0] WDT_CODE_CLEAR   = 8'h4e;
	localparam logic [7:0] WDT_CODE_DISABLE = 8'hb1;
	localparam logic [7:0] WDT_CODE_TRAPSET = 8'hd2;

	// ------------------------------------------------------------
	// Divider taps: one quarter of the detection time
	// ------------------------------------------------------------
	localparam int WDT_DIV_W      = 23;
	localparam int WDT_TAP_FC_MAX = 23;
	localparam int WDT_TAP_FS_MAX = 15;

	// ------------------------------------------------------------
	// Reset pulse: 1.5 us, 375 clock periods of 4 ns
	// ------------------------------------------------------------
	localparam int WDT_CLK_PERIOD_PS = 4000;
	localparam int WDT_RESET_TIME_PS = 1500000;
	localparam int WDT_RESET_CYCLES  = WDT_RESET_TIME_PS / WDT_CLK_PERIOD_PS;

	// ------------------------------------------------------------
	// Bus carrier
	// ------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} wdt_apb_req_s;

	typedef enum {WDT_RUN, WDT_RESET} wdt_state_e;

endpackage

// ===== design/wdt_top.sv
// Watchdog timer with instruction-fetch address trap, APB register slave
//
// Behaviour
// - Binary counters held zero while disabled
// - Field selects four detection times per clock
// - Overflow with select 0 raises interrupt
// - Overflow interrupt ignores the master flag
// - New overflow interrupt always signalled immediately
// - Overflow with select 1 issues reset
// - Reset in low-frequency mode restarts oscillator
// - Trap bits share watchdog register addresses
// - RAM trap setting applies after D2H
// - Special or debug area fetch always traps
// - Trap response bit picks interrupt or reset
// - Trap with response 0 raises interrupt
// - New trap interrupt always signalled immediately
// - Trap with response 1 issues reset
// - Disable code accepted only when enable 0
// - Output select cannot return to 1
// - Clear code resets counter, not divider
// - Counter pauses in stop, idle, sleep
`timescale 1ns/100ps
module wdt_top #(
	parameter logic [15:0] SFR_LO  = 16'h0000,
	parameter logic [15:0] SFR_HI  = 16'h003f,
	parameter logic [15:0] DBR_LO  = 16'h0f80,
	parameter logic [15:0] DBR_HI  = 16'h0fff,
	parameter logic [15:0] RAM_LO  = 16'h0040,
	parameter logic [15:0] RAM_HI  = 16'h023f
) (
	// Clock, reset, enable
	input  wire logic                  MCLK,
	input  wire logic                  RST_N,
	input  wire logic                  CE,
	// APB slave
	input  wire wdt_pkg::wdt_apb_req_s APB_REQ,
	output logic [31:0]                PRDATA,
	output logic                       PREADY,
	output logic                       PSLVERR,
	// Clock ticks and operating mode
	input  wire logic                  FC_TICK,
	input  wire logic                  FS_TICK,
	input  wire logic                  LOW_FREQ_MODE,
	input  wire logic                  PRESCALER_SOURCE_SELECT,
	input  wire logic                  PAUSE_MODE,
	// Instruction fetch monitor
	input  wire logic                  FETCH_VALID,
	input  wire logic [15:0]           FETCH_ADDR,
	// Requests to the core and clock generator
	output logic                       OVERFLOW_INTERRUPT,
	output logic                       FETCH_TRAP_INTERRUPT,
	output logic                       RESET_REQ,
	output logic                       HF_OSC_RESTART
);
	import wdt_pkg::*;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic        pready_reg;
	wire         acc_phase  = APB_REQ.psel & APB_REQ.penable;
	wire         acc_done   = acc_phase & pready_reg & CE;
	wire         hit_config = APB_REQ.paddr == WDT_CONFIG_OFS;
	wire         hit_code   = APB_REQ.paddr == WDT_CODE_OFS;
	wire         hit_status = APB_REQ.paddr == WDT_STATUS_OFS;
	wire         addr_ok    = hit_config | hit_code | hit_status;
	wire         wr_fire    = acc_done & APB_REQ.pwrite;
	wire         cfg_wr     = wr_fire & hit_config;
	wire         code_wr    = wr_fire & hit_code;
	wire [7:0]   code_val   = APB_REQ.pwdata[7:0];
	wire [5:0]   cfg_val    = APB_REQ.pwdata[5:0];

	// ------------------------------------------------------------
	// Control state
	// ------------------------------------------------------------
	logic [5:0]  config_reg;
	logic [5:0]  config_next;
	logic        active_reg;
	logic        sel_lock_reg;
	logic        ram_trap_reg;
	logic [WDT_DIV_W-1:0] div_reg;
	logic [1:0]  bin_cnt_reg;
	logic [1:0]  bin_cnt_next;
	logic [8:0]  rst_cnt_reg;
	wdt_state_e  state_reg;

	wire         enable_bit = config_reg[WDT_ENABLE_BIT];
	wire         out_sel    = config_reg[WDT_OUTSEL_BIT];
	wire         trap_sel   = config_reg[WDT_TRAPSEL_BIT];
	wire [1:0]   time_sel   = config_reg[WDT_TIME_LSB+1:WDT_TIME_LSB];

	// Trap bits live in the watchdog config word
	always_comb begin
		config_next = config_reg;
		if (cfg_wr) begin
			config_next = cfg_val;
			if (sel_lock_reg)
				config_next[WDT_OUTSEL_BIT] = 1'b0;
		end
	end

	wire         clear_cmd   = code_wr & (code_val == WDT_CODE_CLEAR);
	// Disable only after enable bit cleared
	wire         disable_cmd = code_wr & (code_val == WDT_CODE_DISABLE) & ~enable_bit;
	wire         trapset_cmd = code_wr & (code_val == WDT_CODE_TRAPSET);

	// ------------------------------------------------------------
	// Divider and binary counter
	// ------------------------------------------------------------
	// Slow source whenever the core runs slow or the prescaler picks it
	wire         use_fs   = LOW_FREQ_MODE | PRESCALER_SOURCE_SELECT;
	wire         src_tick = (use_fs ? FS_TICK : FC_TICK) & ~PAUSE_MODE;
	// Tap at a quarter of the selected detection time
	wire [4:0]   tap_base = use_fs ? 5'(WDT_TAP_FS_MAX) : 5'(WDT_TAP_FC_MAX);
	wire [4:0]   tap_n    = tap_base - {2'b00, time_sel, 1'b0};
	wire [WDT_DIV_W-1:0] tap_mask = ~({WDT_DIV_W{1'b1}} << tap_n);
	wire         bin_tick = src_tick & ((div_reg & tap_mask) == tap_mask);
	wire         overflow = bin_tick & active_reg & (bin_cnt_reg == 2'h3) & ~clear_cmd;

	always_comb begin
		bin_cnt_next = bin_cnt_reg;
		if (!active_reg || disable_cmd)
			bin_cnt_next = 2'h0;
		// Clear touches only the binary counter
		else if (clear_cmd)
			bin_cnt_next = 2'h0;
		// Stop, idle and sleep freeze the count
		else if (bin_tick)
			bin_cnt_next = bin_cnt_reg + 2'h1;
	end

	// ------------------------------------------------------------
	// Fetch trap decode
	// ------------------------------------------------------------
	wire in_sfr = (FETCH_ADDR >= SFR_LO) & (FETCH_ADDR <= SFR_HI);
	wire in_dbr = (FETCH_ADDR >= DBR_LO) & (FETCH_ADDR <= DBR_HI);
	wire in_ram = (FETCH_ADDR >= RAM_LO) & (FETCH_ADDR <= RAM_HI);
	// Special and debug areas trap unconditionally
	wire trap_hit = FETCH_VALID & (in_sfr | in_dbr | (in_ram & ram_trap_reg));

	wire trap_irq = trap_hit & ~trap_sel;
	wire trap_rst = trap_hit & trap_sel;
	wire wdt_irq  = overflow & ~out_sel;
	wire wdt_rst  = overflow & out_sel;
	wire rst_evt  = (trap_rst | wdt_rst) & (state_reg == WDT_RUN);

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			config_reg   <= WDT_CONFIG_RST;
			active_reg   <= 1'b1;
			sel_lock_reg <= 1'b0;
			ram_trap_reg <= WDT_CONFIG_RST[WDT_RAMTRAP_BIT];
			div_reg      <= '0;
			bin_cnt_reg  <= 2'h0;
		end else if (CE) begin
			config_reg  <= config_next;
			bin_cnt_reg <= bin_cnt_next;
			// Divider keeps running through a clear
			if (src_tick)
				div_reg <= div_reg + 1'b1;
			if (cfg_wr && !cfg_val[WDT_OUTSEL_BIT])
				sel_lock_reg <= 1'b1;
			if (disable_cmd)
				active_reg <= 1'b0;
			else if (cfg_wr && cfg_val[WDT_ENABLE_BIT])
				active_reg <= 1'b1;
			// RAM trap setting applied by code
			if (trapset_cmd)
				ram_trap_reg <= config_reg[WDT_RAMTRAP_BIT];
		end
	end

	// ------------------------------------------------------------
	// Requests to the core and clock generator
	// ------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			OVERFLOW_INTERRUPT   <= 1'b0;
			FETCH_TRAP_INTERRUPT <= 1'b0;
			RESET_REQ            <= 1'b0;
			HF_OSC_RESTART       <= 1'b0;
			rst_cnt_reg          <= 9'h000;
			state_reg            <= WDT_RUN;
		end else if (CE) begin
			// Every overflow with select 0 is signalled at once
			OVERFLOW_INTERRUPT   <= wdt_irq;
			// Every trap with response 0 is signalled at once
			FETCH_TRAP_INTERRUPT <= trap_irq;
			case (state_reg)
				WDT_RUN: begin
					if (rst_evt) begin
						state_reg      <= WDT_RESET;
						RESET_REQ      <= 1'b1;
						rst_cnt_reg    <= 9'(WDT_RESET_CYCLES - 1);
						// Slow mode restarts the fast oscillator
						HF_OSC_RESTART <= LOW_FREQ_MODE;
					end
				end
				WDT_RESET: begin
					if (rst_cnt_reg == 9'h000) begin
						state_reg      <= WDT_RUN;
						RESET_REQ      <= 1'b0;
						HF_OSC_RESTART <= 1'b0;
					end else begin
						rst_cnt_reg <= rst_cnt_reg - 9'h001;
					end
				end
				default: state_reg <= WDT_RUN;
			endcase
		end
	end

	// ------------------------------------------------------------
	// APB answer: one wait state, data and ready from flops
	// ------------------------------------------------------------
	wire [31:0] status_word = {24'h000000, state_reg == WDT_RESET, sel_lock_reg,
		ram_trap_reg, active_reg, 2'b00, bin_cnt_reg};
	wire [31:0] rd_word = hit_config ? {26'h0, config_reg} :
		(hit_status ? status_word : 32'h00000000);

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			pready_reg <= 1'b0;
			PREADY     <= 1'b0;
			PRDATA     <= 32'h00000000;
			PSLVERR    <= 1'b0;
		end else if (CE) begin
			pready_reg <= acc_phase & ~pready_reg;
			PREADY     <= acc_phase & ~pready_reg;
			PSLVERR    <= acc_phase & ~pready_reg & ~addr_ok;
			if (acc_phase && !pready_reg && !APB_REQ.pwrite)
				PRDATA <= rd_word;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	sequence rst_start_s;
		CE && rst_evt;
	endsequence
	sequence rst_hold_s;
		RESET_REQ [*8];
	endsequence

	cnt_zero_a: assert property (!active_reg |-> bin_cnt_reg == 2'h0)
		else $error("counter not held at zero while disabled");
	ovf_irq_a: assert property (CE && overflow && !out_sel |=> OVERFLOW_INTERRUPT)
		else $error("overflow interrupt missing");
	ovf_rst_a: assert property (rst_start_s |=> RESET_REQ && rst_cnt_reg == 9'(WDT_RESET_CYCLES - 1))
		else $error("reset request missing or wrong length");
	rst_hold_a: assert property (rst_start_s |=> rst_hold_s)
		else $error("reset request dropped early");
	osc_restart_a: assert property ((rst_start_s and LOW_FREQ_MODE) |=> HF_OSC_RESTART)
		else $error("oscillator restart missing");
	disable_ign_a: assert property (code_wr && code_val == WDT_CODE_DISABLE && enable_bit && active_reg |=> active_reg)
		else $error("disable accepted while enable set");
	sel_lock_a: assert property (sel_lock_reg |=> !out_sel)
		else $error("output select returned to one");
	trap_irq_a: assert property (CE && FETCH_VALID && in_sfr && !trap_sel |=> FETCH_TRAP_INTERRUPT)
		else $error("special area fetch did not trap");
	trap_rst_a: assert property (CE && trap_hit && trap_sel && state_reg == WDT_RUN |=> RESET_REQ)
		else $error("trap reset missing");
	pause_hold_a: assert property (PAUSE_MODE && !code_wr |=> $stable(bin_cnt_reg))
		else $error("counter moved in pause");
	clear_cnt_a: assert property (clear_cmd |=> bin_cnt_reg == 2'h0)
		else $error("clear code did not clear counter");

endmodule

// ===== testbench/watchdog_with_address_trap_bench.sv
// Self-checking bench for the watchdog and fetch-trap block
`timescale 1ns/100ps
module watchdog_with_address_trap_bench;
	import wdt_pkg::*;
	logic         mclk, rst_n, fs_tick, low_freq, pause;
	wdt_apb_req_s req;
	logic [31:0]  prdata, rd;
	logic         pready, pslverr, er, ovf_int, trap_int, reset_req, osc_restart;
	logic         f_valid, ce, fc_tick, fs_src;
	logic [15:0]  f_addr;
	int           fail_count, checks, n;

	wdt_top u_dut (.MCLK(mclk), .RST_N(rst_n), .CE(ce), .APB_REQ(req), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .FC_TICK(fc_tick), .FS_TICK(fs_tick),
		.LOW_FREQ_MODE(low_freq), .PRESCALER_SOURCE_SELECT(fs_src), .PAUSE_MODE(pause),
		.FETCH_VALID(f_valid), .FETCH_ADDR(f_addr), .OVERFLOW_INTERRUPT(ovf_int),
		.FETCH_TRAP_INTERRUPT(trap_int), .RESET_REQ(reset_req), .HF_OSC_RESTART(osc_restart));
	wdt_core_model u_core (.clk(mclk), .fetch_valid(f_valid), .fetch_addr(f_addr));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	// Request held until pready is sampled high at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge mclk);
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge mclk);
		req.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		er = pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask
	function automatic logic sig(input int w);
		case (w)
			0: return ovf_int;
			1: return trap_int;
			default: return reset_req;
		endcase
	endfunction
	task automatic wait_for(input int w, input int hi);
		n = 0;
		while (sig(w) !== 1'b1 && n < hi) begin
			@(posedge mclk);
			n++;
		end
	endtask
	// Counts edges with the reset request high, then lets it drop
	task automatic reset_len(input string s, input logic osc);
		wait_for(2, 4);
		chk("osc restart", {31'h0, osc}, {31'h0, osc_restart});
		n = 0;
		while (reset_req === 1'b1 && n < 500) begin
			@(posedge mclk);
			n++;
		end
		chk(s, 32'(WDT_RESET_CYCLES), 32'(n));
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_state;
		apb(1'b0, WDT_CONFIG_OFS, 32'h0);
		chk("config", 32'(WDT_CONFIG_RST), rd & 32'h3f);
		apb(1'b0, WDT_STATUS_OFS, 32'h0);
		chk("status", 32'h30, rd & 32'h33);
		apb(1'b0, 12'h040, 32'h0);
		chk("unmapped", 32'h1, {31'h0, er});
		$display("done reset state");
	endtask
	task automatic t_trap_resets;
		u_core.fetch(16'h0010);
		reset_len("sfr trap reset", 1'b0);
		low_freq <= 1'b1;
		u_core.fetch(16'h0f90);
		reset_len("dbr trap reset", 1'b1);
		low_freq <= 1'b0;
		$display("done trap resets");
	endtask
	task automatic t_overflow_reset;
		apb(1'b1, WDT_CONFIG_OFS, 32'h3f);
		apb(1'b1, WDT_CODE_OFS, 32'(WDT_CODE_CLEAR));
		wait_for(2, 2100);
		chk("reset window", 32'h1, {31'h0, n >= 1530 && n < 2100});
		reset_len("overflow reset", 1'b0);
		$display("done overflow reset");
	endtask
	task automatic t_trap_int;
		apb(1'b1, WDT_CONFIG_OFS, 32'h0e);
		u_core.fetch(16'h0100);
		wait_for(1, 4);
		chk("ram trap before apply", 32'h1, {31'h0, trap_int});
		apb(1'b1, WDT_CODE_OFS, 32'(WDT_CODE_TRAPSET));
		u_core.fetch(16'h0100);
		wait_for(1, 4);
		chk("ram trap after apply", 32'h0, {31'h0, trap_int});
		u_core.fetch(16'h003f);
		wait_for(1, 4);
		chk("sfr trap int", 32'h1, {31'h0, trap_int});
		chk("no reset", 32'h0, {31'h0, reset_req});
		$display("done trap interrupts");
	endtask
	task automatic t_overflow_int;
		apb(1'b1, WDT_CODE_OFS, 32'(WDT_CODE_CLEAR));
		wait_for(0, 1200);
		chk("early overflow", 32'h0, {31'h0, ovf_int});
		apb(1'b1, WDT_CODE_OFS, 32'h77);
		apb(1'b0, WDT_STATUS_OFS, 32'h0);
		chk("other code", 32'h10, rd & 32'h30);
		apb(1'b1, WDT_CODE_OFS, 32'(WDT_CODE_CLEAR));
		pause <= 1'b1;
		wait_for(0, 2500);
		chk("paused", 32'h0, {31'h0, ovf_int});
		pause <= 1'b0;
		wait_for(0, 2100);
		chk("int window", 32'h1, {31'h0, n < 2100});
		@(posedge mclk);
		chk("int pulse", 32'h0, {31'h0, ovf_int});
		apb(1'b1, WDT_CONFIG_OFS, 32'h0f);
		apb(1'b0, WDT_CONFIG_OFS, 32'h0);
		chk("select lock", 32'h0e, rd & 32'h3f);
		$display("done overflow interrupt");
	endtask
	// Clock enable freezes the trap path; the tick source follows mode and select
	task automatic t_source;
		ce <= 1'b0;
		u_core.fetch(16'h0020);
		wait_for(1, 4);
		chk("frozen trap", 32'h0, {31'h0, trap_int});
		ce      <= 1'b1;
		fs_src  <= 1'b0;
		fc_tick <= 1'b0;
		apb(1'b1, WDT_CODE_OFS, 32'(WDT_CODE_CLEAR));
		wait_for(0, 2500);
		chk("fast source idle", 32'h0, {31'h0, ovf_int});
		low_freq <= 1'b1;
		wait_for(0, 2100);
		chk("slow mode source", 32'h1, {31'h0, n < 2100});
		low_freq <= 1'b0;
		fs_src   <= 1'b1;
		fc_tick  <= 1'b1;
		$display("done clock source");
	endtask
	task automatic t_disable;
		apb(1'b1, WDT_CODE_OFS, 32'(WDT_CODE_DISABLE));
		apb(1'b0, WDT_STATUS_OFS, 32'h0);
		chk("disable refused", 32'h10, rd & 32'h10);
		apb(1'b1, WDT_CODE_OFS, 32'(WDT_CODE_CLEAR));
		apb(1'b1, WDT_CONFIG_OFS, 32'h06);
		apb(1'b1, WDT_CODE_OFS, 32'(WDT_CODE_DISABLE));
		wait_for(0, 2500);
		chk("disabled no int", 32'h0, {31'h0, ovf_int});
		apb(1'b0, WDT_STATUS_OFS, 32'h0);
		chk("disabled status", 32'h0, rd & 32'h13);
		$display("done disable");
	endtask

	initial begin
		fail_count = 0;
		checks     = 0;
		rst_n      = 1'b0;
		fs_tick    = 1'b1;
		ce         = 1'b1;
		fc_tick    = 1'b1;
		fs_src     = 1'b1;
		low_freq   = 1'b0;
		pause      = 1'b0;
		req        = '0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset_state();
		t_trap_resets();
		t_overflow_reset();
		t_trap_int();
		t_overflow_int();
		t_source();
		t_disable();
		tally_and_finish();
	end
	initial begin
		repeat (40000) @(posedge mclk);
		fail_count++;
		$display("[FAIL] watchdog expected finish seen timeout");
		tally_and_finish();
	end
endmodule

// ===== testbench/wdt_core_model.sv
// Instruction-fetch side of the core, seen by the trap monitor
`timescale 1ns/100ps
module wdt_core_model (
	// Clock
	input  wire logic   clk,
	// Fetch stream
	output logic        fetch_valid,
	output logic [15:0] fetch_addr
);
	initial begin
		fetch_valid = 1'b0;
		fetch_addr  = 16'h1000;
	end
	// ----------------------------------------
	// Fetch cycle
	// ----------------------------------------
	// Address is inverted after the cycle so a stale value never looks held
	task automatic fetch(input logic [15:0] a);
		@(posedge clk);
		fetch_valid <= 1'b1;
		fetch_addr  <= a;
		@(posedge clk);
		fetch_valid <= 1'b0;
		fetch_addr  <= ~a;
	endtask
endmodule
